// File: core/dcm_pkg.sv
// package: constants, keyword tables and carrier structs for the class match block
// Operation
// - with source ipv6 matching on, the leading prefix-length bits of the source address must equal the configured source prefix.
// - with destination ipv6 matching on, the leading prefix-length bits of the destination address must equal the configured prefix.
// - with source port matching on, a tcp/udp source port matches when equal to the port, or inside the range when a range is set.
// - with destination port matching on, a tcp/udp destination port matches when equal to the port, or inside the range when set.
// - a selected service keyword supplies the port number and overrides the configured port and range.
// - with code-point matching on, the upper six bits of the service type octet are compared with the configured code point.
// - the code point comes from a keyword translated to its value, or from a raw value ignored whenever a keyword is chosen.
// - with precedence matching on, the upper three bits of the service type octet must equal the configured precedence.
// - with type-of-service matching on, the whole eight-bit service type octet is compared with an eight-bit value.
// - only positions set in the eight-bit mask take part in the type-of-service compare.
package dcm_pkg;

  localparam int ADDR_W = 128;
  localparam int PLEN_W = 8;
  localparam int PORT_W = 16;
  localparam int CP_W = 6;
  localparam int PREC_W = 3;
  localparam int TOS_W = 8;
  localparam int KW_W = 4;
  localparam int CP_LSB = 2;
  localparam int PREC_LSB = 5;
  localparam logic [PLEN_W-1:0] PLEN_MAX = 8'h80;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_PFX0 = 8'h10;
  localparam logic [7:0] OFS_DST_PFX0 = 8'h20;
  localparam logic [7:0] OFS_PLEN = 8'h30;
  localparam logic [7:0] OFS_SPORT = 8'h34;
  localparam logic [7:0] OFS_DPORT = 8'h38;
  localparam logic [7:0] OFS_KW = 8'h3C;
  localparam logic [7:0] OFS_TOS = 8'h40;
  localparam logic [7:0] OFS_STAT = 8'h44;
  localparam logic [7:0] OFS_HITS = 8'h48;

  // control register bit positions
  localparam int EN_SRC6 = 0;
  localparam int EN_DST6 = 1;
  localparam int EN_SPORT = 2;
  localparam int EN_DPORT = 3;
  localparam int EN_DSCP = 4;
  localparam int EN_PREC = 5;
  localparam int EN_TOS = 6;
  localparam int SRANGE_BIT = 8;
  localparam int DRANGE_BIT = 9;
  localparam int CTRL_W = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // number of criteria in the match vector; the control register bit positions serve as their indices
  localparam int NCRIT = 7;

  typedef struct packed {
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [PORT_W-1:0] src_port;
    logic [PORT_W-1:0] dst_port;
    logic l4_valid;
    logic [TOS_W-1:0] svc_type;
  } dcm_hdr_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [NCRIT-1:0] crit;
  } dcm_result_type;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [ADDR_W-1:0] src_pfx;
    logic [ADDR_W-1:0] dst_pfx;
    logic [PLEN_W-1:0] src_plen;
    logic [PLEN_W-1:0] dst_plen;
    logic [PORT_W-1:0] sport_lo;
    logic [PORT_W-1:0] sport_hi;
    logic [PORT_W-1:0] dport_lo;
    logic [PORT_W-1:0] dport_hi;
    logic [KW_W-1:0] skw;
    logic [KW_W-1:0] dkw;
    logic [KW_W-1:0] cpkw;
    logic [CP_W-1:0] cp_raw;
    logic [PREC_W-1:0] prec;
    logic [TOS_W-1:0] tos_bits;
    logic [TOS_W-1:0] tos_mask;
  } dcm_cfg_type;

  // service keyword to port; code 0 means no keyword
  function automatic logic [PORT_W-1:0] kw_port(input logic [KW_W-1:0] kw);
    logic [PORT_W-1:0] p;
    p = 16'h0000;
    case (kw)
      4'h1: p = 16'h0015;
      4'h2: p = 16'h0016;
      4'h3: p = 16'h0017;
      4'h4: p = 16'h0019;
      4'h5: p = 16'h0035;
      4'h6: p = 16'h0045;
      4'h7: p = 16'h0050;
      4'h8: p = 16'h006E;
      4'h9: p = 16'h007B;
      4'hA: p = 16'h00A1;
      4'hB: p = 16'h01BB;
      default: p = 16'h0000;
    endcase
    return p;
  endfunction

  // code-point keyword to value; code 0 means raw value
  function automatic logic [CP_W-1:0] kw_dscp(input logic [KW_W-1:0] kw);
    logic [CP_W-1:0] v;
    v = 6'h00;
    case (kw)
      4'h1: v = 6'h00;
      4'h2: v = 6'h0A;
      4'h3: v = 6'h12;
      4'h4: v = 6'h1A;
      4'h5: v = 6'h22;
      4'h6: v = 6'h2E;
      4'h7: v = 6'h08;
      4'h8: v = 6'h10;
      4'h9: v = 6'h18;
      4'hA: v = 6'h20;
      4'hB: v = 6'h28;
      4'hC: v = 6'h30;
      4'hD: v = 6'h38;
      default: v = 6'h00;
    endcase
    return v;
  endfunction

  // prefix mask with the top plen bits set
  function automatic logic [ADDR_W-1:0] pfx_mask(input logic [PLEN_W-1:0] plen);
    logic [ADDR_W-1:0] m;
    m = '0;
    for (int i = 0; i < ADDR_W; i++) begin
      if (i < int'(plen)) begin
        m[ADDR_W-1-i] = 1'b1;
      end
    end
    return m;
  endfunction

endpackage

// File: core/dcm_port_match.sv
// port criterion: keyword, exact port or continuous range
`timescale 1ns/1ps
module dcm_port_match
  import dcm_pkg::*;
(
  input wire logic [dcm_pkg::PORT_W-1:0] pkt_port,
  input wire logic [dcm_pkg::KW_W-1:0] kw,
  input wire logic range_en,
  input wire logic [dcm_pkg::PORT_W-1:0] lo,
  input wire logic [dcm_pkg::PORT_W-1:0] hi,
  output logic hit
);
  always_comb begin
    if (kw != '0) begin
      hit = (pkt_port == kw_port(kw));
    end else if (range_en) begin
      hit = (pkt_port >= lo) && (pkt_port <= hi);
    end else begin
      hit = (pkt_port == lo);
    end
  end
endmodule

// File: core/dcm_prefix_match.sv
// ipv6 prefix criterion: leading plen bits must agree
`timescale 1ns/1ps
module dcm_prefix_match
  import dcm_pkg::*;
(
  input wire logic [dcm_pkg::ADDR_W-1:0] addr,
  input wire logic [dcm_pkg::ADDR_W-1:0] pfx,
  input wire logic [dcm_pkg::PLEN_W-1:0] plen,
  output logic hit
);
  logic [ADDR_W-1:0] m;
  always_comb begin
    m = pfx_mask(plen);
    hit = ((addr ^ pfx) & m) == '0;
  end
endmodule

// File: core/dcm_class_match.sv
// class match top: apb config registers, criterion compare, registered result
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dcm_class_match
  import dcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hdr_valid,
  input wire dcm_pkg::dcm_hdr_type hdr,
  output dcm_pkg::dcm_result_type result
);

  typedef struct packed {
    dcm_cfg_type cfg;
    dcm_result_type res;
    logic [31:0] rdata;
    logic err;
    logic [31:0] hits;
  } dcm_state_type;

  dcm_state_type s_q;
  dcm_state_type s_d;

  logic src6_hit;
  logic dst6_hit;
  logic sport_hit;
  logic dport_hit;
  logic [CP_W-1:0] cp_cfg;
  logic [NCRIT-1:0] crit;
  logic [NCRIT-1:0] en;
  logic all_hit;
  logic wr;
  logic rd;
  logic [1:0] word;

  dcm_prefix_match u_src6 (
    .addr(hdr.src_addr),
    .pfx(s_q.cfg.src_pfx),
    .plen(s_q.cfg.src_plen),
    .hit(src6_hit)
  );

  dcm_prefix_match u_dst6 (
    .addr(hdr.dst_addr),
    .pfx(s_q.cfg.dst_pfx),
    .plen(s_q.cfg.dst_plen),
    .hit(dst6_hit)
  );

  dcm_port_match u_sport (
    .pkt_port(hdr.src_port),
    .kw(s_q.cfg.skw),
    .range_en(s_q.cfg.ctrl[SRANGE_BIT]),
    .lo(s_q.cfg.sport_lo),
    .hi(s_q.cfg.sport_hi),
    .hit(sport_hit)
  );

  dcm_port_match u_dport (
    .pkt_port(hdr.dst_port),
    .kw(s_q.cfg.dkw),
    .range_en(s_q.cfg.ctrl[DRANGE_BIT]),
    .lo(s_q.cfg.dport_lo),
    .hi(s_q.cfg.dport_hi),
    .hit(dport_hit)
  );

  always_comb begin
    // keyword wins over the raw code point
    cp_cfg = (s_q.cfg.cpkw != '0) ? kw_dscp(s_q.cfg.cpkw) : s_q.cfg.cp_raw;
    crit[EN_SRC6] = src6_hit;
    crit[EN_DST6] = dst6_hit;
    crit[EN_SPORT] = hdr.l4_valid && sport_hit;
    crit[EN_DPORT] = hdr.l4_valid && dport_hit;
    crit[EN_DSCP] = hdr.svc_type[TOS_W-1:CP_LSB] == cp_cfg;
    crit[EN_PREC] = hdr.svc_type[TOS_W-1:PREC_LSB] == s_q.cfg.prec;
    crit[EN_TOS] = ((hdr.svc_type ^ s_q.cfg.tos_bits) & s_q.cfg.tos_mask) == '0;
    en = s_q.cfg.ctrl[NCRIT-1:0];
    all_hit = &(crit | ~en);
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign word = paddr[3:2];
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.err;
  assign result = s_q.res;

  function automatic logic mapped(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'b00) begin
      ok = (a <= OFS_HITS);
      if (a > OFS_TOS && a < OFS_STAT) begin
        ok = 1'b0;
      end
      if (a > OFS_CTRL && a < OFS_SRC_PFX0) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.res.valid = hdr_valid;
    if (hdr_valid) begin
      s_d.res.hit = all_hit;
      s_d.res.crit = crit & en;
      if (all_hit) begin
        s_d.hits = s_q.hits + 32'h0000_0001;
      end
    end else begin
      s_d.res.hit = 1'b0;
    end
    // read data prepared in the setup cycle, error flagged for the access phase
    if (psel && !penable) begin
      s_d.err = !mapped(paddr);
    end
    if (rd) begin
      s_d.rdata = 32'h0000_0000;
      if (paddr >= OFS_SRC_PFX0 && paddr < OFS_DST_PFX0) begin
        s_d.rdata = s_q.cfg.src_pfx[32*(3-int'(word)) +: 32];
      end else if (paddr >= OFS_DST_PFX0 && paddr < OFS_PLEN) begin
        s_d.rdata = s_q.cfg.dst_pfx[32*(3-int'(word)) +: 32];
      end else begin
        unique case (paddr)
          OFS_CTRL: s_d.rdata = {22'h000000, s_q.cfg.ctrl};
          OFS_PLEN: s_d.rdata = {16'h0000, s_q.cfg.dst_plen, s_q.cfg.src_plen};
          OFS_SPORT: s_d.rdata = {s_q.cfg.sport_hi, s_q.cfg.sport_lo};
          OFS_DPORT: s_d.rdata = {s_q.cfg.dport_hi, s_q.cfg.dport_lo};
          OFS_KW: s_d.rdata = {14'h0000, s_q.cfg.cp_raw, s_q.cfg.cpkw, s_q.cfg.dkw,
                               s_q.cfg.skw};
          OFS_TOS: s_d.rdata = {13'h0000, s_q.cfg.prec, s_q.cfg.tos_mask, s_q.cfg.tos_bits};
          OFS_STAT: s_d.rdata = {23'h000000, s_q.res.crit, s_q.res.hit, s_q.res.valid};
          OFS_HITS: s_d.rdata = s_q.hits;
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr && !s_q.err) begin
      if (paddr >= OFS_SRC_PFX0 && paddr < OFS_DST_PFX0) begin
        s_d.cfg.src_pfx[32*(3-int'(word)) +: 32] = pwdata;
      end else if (paddr >= OFS_DST_PFX0 && paddr < OFS_PLEN) begin
        s_d.cfg.dst_pfx[32*(3-int'(word)) +: 32] = pwdata;
      end else begin
        unique case (paddr)
          OFS_CTRL: s_d.cfg.ctrl = pwdata[CTRL_W-1:0];
          OFS_PLEN: begin
            s_d.cfg.src_plen = (pwdata[7:0] > PLEN_MAX) ? PLEN_MAX : pwdata[7:0];
            s_d.cfg.dst_plen = (pwdata[15:8] > PLEN_MAX) ? PLEN_MAX : pwdata[15:8];
          end
          OFS_SPORT: begin
            s_d.cfg.sport_lo = pwdata[15:0];
            s_d.cfg.sport_hi = pwdata[31:16];
          end
          OFS_DPORT: begin
            s_d.cfg.dport_lo = pwdata[15:0];
            s_d.cfg.dport_hi = pwdata[31:16];
          end
          OFS_KW: begin
            s_d.cfg.skw = pwdata[3:0];
            s_d.cfg.dkw = pwdata[7:4];
            s_d.cfg.cpkw = pwdata[11:8];
            s_d.cfg.cp_raw = pwdata[17:12];
          end
          OFS_TOS: begin
            s_d.cfg.tos_bits = pwdata[7:0];
            s_d.cfg.tos_mask = pwdata[15:8];
            s_d.cfg.prec = pwdata[18:16];
          end
          OFS_HITS: s_d.hits = 32'h0000_0000;
          default: s_d.hits = s_d.hits;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

endmodule

// File: verif/dcm_class_match_props.sv
// checker: port-level properties of the class match block
`timescale 1ns/1ps
module dcm_class_match_props
  import dcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hdr_valid,
  input wire dcm_pkg::dcm_hdr_type hdr,
  input wire dcm_pkg::dcm_result_type result
);
  logic [31:0] ctrl_q, kw_q, tos_q, sport_q;
  logic wr;
  logic [6:0] en;
  assign wr = clk_en && psel && penable && pwrite;
  assign en = ctrl_q[6:0];
  // shadow of the configuration seen on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      kw_q <= '0;
      tos_q <= '0;
      sport_q <= '0;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl_q <= pwdata;
      if (paddr == OFS_KW) kw_q <= pwdata;
      if (paddr == OFS_TOS) tos_q <= pwdata;
      if (paddr == OFS_SPORT) sport_q <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_valid_latency: assert property (hdr_valid && clk_en |=> result.valid)
    else $error("result valid missing after header");
  a_no_stray_valid: assert property (clk_en && !hdr_valid |=> !result.valid)
    else $error("result valid without header");
  a_hit_all_crit: assert property (result.valid |-> result.hit == (result.crit == en))
    else $error("hit disagrees with enabled criteria");
  a_crit_enabled: assert property (result.valid |-> (result.crit & ~en) == 7'h00)
    else $error("disabled criterion reported");
  a_prec_field: assert property (result.valid && en[EN_PREC] |->
    result.crit[EN_PREC] == ($past(hdr.svc_type[7:5]) == tos_q[18:16]))
    else $error("precedence compare wrong");
  a_tos_masked: assert property (result.valid && en[EN_TOS] |->
    result.crit[EN_TOS] == ((($past(hdr.svc_type) ^ tos_q[7:0]) & tos_q[15:8]) == 8'h00))
    else $error("masked service type compare wrong");
  a_dscp_raw: assert property (result.valid && en[EN_DSCP] && kw_q[11:8] == 4'h0 |->
    result.crit[EN_DSCP] == ($past(hdr.svc_type[7:2]) == kw_q[17:12]))
    else $error("raw code point compare wrong");
  a_sport_exact: assert property (result.valid && en[EN_SPORT] && !ctrl_q[SRANGE_BIT]
    && kw_q[3:0] == 4'h0 |-> result.crit[EN_SPORT] ==
    ($past(hdr.l4_valid) && $past(hdr.src_port) == sport_q[15:0]))
    else $error("exact source port compare wrong");
  c_hit: cover property (result.valid && result.hit);
  c_miss: cover property (result.valid && !result.hit);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind dcm_class_match dcm_class_match_props chk_u (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hdr_valid, .hdr, .result);

// File: verif/dcm_hdr_source.sv
// partner: frame header parser model feeding one header per call
`timescale 1ns/1ps
module dcm_hdr_source
  import dcm_pkg::*;
(
  input wire logic pclk,
  output logic hdr_valid,
  output dcm_pkg::dcm_hdr_type hdr
);
  initial begin
    hdr_valid = 1'b0;
    hdr = '1;
  end
  // released header bus shows the inverse so stale values never match
  task automatic send(input dcm_hdr_type h);
    hdr_valid <= 1'b1;
    hdr <= h;
    @(posedge pclk);
    hdr_valid <= 1'b0;
    hdr <= ~h;
  endtask
endmodule

// File: verif/dcm_class_match_tb.sv
// testbench: apb configuration and header classification checks
`timescale 1ns/1ps
module dcm_class_match_tb;
  import dcm_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, hdr_valid, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dcm_hdr_type hdr, h;
  dcm_result_type result;
  int error_cnt, samples_checked;
  dcm_class_match dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hdr_valid, .hdr, .result);
  dcm_hdr_source src_u (.pclk, .hdr_valid, .hdr);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cls(input logic e);
    src_u.send(h);
    #1;
    chk("valid", 32'h1, {31'h0, result.valid});
    chk("hit", {31'h0, e}, {31'h0, result.hit});
    @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("checked %0d, wrong %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    h = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    h.l4_valid = 1'b1;
    cls(1'b1);
    apb(1'b1, OFS_SRC_PFX0, 32'hABCD0000);
    apb(1'b1, OFS_DST_PFX0, 32'h12340000);
    apb(1'b1, OFS_PLEN, 32'h00001010);
    apb(1'b1, OFS_CTRL, 32'h00000001);
    h.src_addr = {32'hABCD8000, 96'h0};
    cls(1'b1);
    h.src_addr = {32'hABCC0000, 96'h0};
    cls(1'b0);
    apb(1'b1, OFS_CTRL, 32'h00000002);
    h.dst_addr = {32'h1234FFFF, 96'h0};
    cls(1'b1);
    h.dst_addr = {32'h12350000, 96'h0};
    cls(1'b0);
    $display("test prefix done");
    apb(1'b1, OFS_SPORT, 32'h00C80050);
    apb(1'b1, OFS_CTRL, 32'h00000004);
    h.src_port = 16'h0050;
    cls(1'b1);
    h.src_port = 16'h0051;
    cls(1'b0);
    apb(1'b1, OFS_SPORT, 32'h00C80064);
    apb(1'b1, OFS_CTRL, 32'h00000104);
    h.src_port = 16'h00C8;
    cls(1'b1);
    h.src_port = 16'h00C9;
    cls(1'b0);
    apb(1'b1, OFS_DPORT, 32'h00C80064);
    apb(1'b1, OFS_CTRL, 32'h00000208);
    h.dst_port = 16'h0064;
    cls(1'b1);
    h.dst_port = 16'h0063;
    cls(1'b0);
    apb(1'b1, OFS_KW, 32'h00000070);
    h.dst_port = 16'h0050;
    cls(1'b1);
    h.dst_port = 16'h0064;
    cls(1'b0);
    $display("test ports done");
    apb(1'b1, OFS_KW, 32'h0002E000);
    apb(1'b1, OFS_CTRL, 32'h00000010);
    h.svc_type = 8'hBB;
    cls(1'b1);
    h.svc_type = 8'hBC;
    cls(1'b0);
    apb(1'b1, OFS_KW, 32'h00001600);
    h.svc_type = 8'hB8;
    cls(1'b1);
    h.svc_type = 8'h04;
    cls(1'b0);
    apb(1'b1, OFS_TOS, 32'h0005F05A);
    apb(1'b1, OFS_CTRL, 32'h00000020);
    h.svc_type = 8'hBF;
    cls(1'b1);
    h.svc_type = 8'hC0;
    cls(1'b0);
    apb(1'b1, OFS_CTRL, 32'h00000040);
    h.svc_type = 8'h5F;
    cls(1'b1);
    h.svc_type = 8'h4A;
    cls(1'b0);
    apb(1'b1, OFS_CTRL, 32'h00000060);
    h.svc_type = 8'hA0;
    cls(1'b0);
    $display("test service type done");
    apb(1'b0, OFS_TOS, 32'h0);
    chk("tos reg", 32'h0005F05A, rd);
    chk("pslverr ok", 32'h0, {31'h0, er});
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat", 32'h00000080, rd);
    apb(1'b0, OFS_HITS, 32'h0);
    chk("hits", 32'h0000000B, rd);
    apb(1'b1, OFS_HITS, 32'h0);
    apb(1'b0, OFS_HITS, 32'h0);
    chk("hits clear", 32'h0, rd);
    clk_en <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000007F);
    clk_en <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("frozen ctrl", 32'h00000060, rd);
    apb(1'b0, 8'hFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("prdata", 32'h0, rd);
    $display("test bus done");
    end_sim();
  end
endmodule
